/* File: common/dtp_pkg.sv */
// timer package: register map, field layouts, reset values
// assumes a single 10 mhz system clock and a 32-bit avalon-mm register bus
package dtp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int unsigned CNT_W  = 10;
  localparam int unsigned REG_W  = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 3;
  localparam int unsigned IDX_LO = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_TIMER_COUNT       = 3'h0;
  localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL_ONE = 3'h1;
  localparam logic [IDX_W-1:0] IDX_TIMER_CONTROL_TWO = 3'h2;
  localparam logic [IDX_W-1:0] IDX_PWM_DUTY_LOW      = 3'h3;
  localparam logic [IDX_W-1:0] IDX_PRESCALER_VALUE   = 3'h4;
  localparam logic [IDX_W-1:0] IDX_BUZZER_CONTROL    = 3'h5;
  localparam logic [IDX_W-1:0] IDX_TIMER_HIGH_BITS   = 3'h6;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [REG_W-1:0] RST_CONTROL_ONE  = 8'h00;
  localparam logic [REG_W-1:0] RST_CONTROL_TWO  = 8'h3f;
  localparam logic [REG_W-1:0] RST_PRESCALER    = 8'hff;
  localparam logic [REG_W-1:0] RST_BUZZER       = 8'h0f;
  localparam logic [REG_W-1:0] RST_ZERO8        = 8'h00;
  localparam logic [CNT_W-1:0] RST_COUNT        = 10'h000;
  localparam logic [CNT_W-1:0] CNT_FULL         = 10'h3ff;
  localparam logic [CNT_W-1:0] CNT_ZERO         = 10'h000;
  localparam logic [CNT_W-1:0] CNT_ONE          = 10'h001;
  localparam logic [DATA_W-1:0] RD_ZERO         = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // high-bits register layout: reload bits at [5:4], duty bits at [1:0]
  localparam int unsigned HB_RELOAD_HI = 5;
  localparam int unsigned HB_RELOAD_LO = 4;
  localparam int unsigned HB_DUTY_HI   = 1;
  localparam int unsigned HB_DUTY_LO   = 0;
  localparam logic [REG_W-1:0] HB_WMASK = 8'h33;

  // buzzer control layout
  localparam int unsigned BZ_EN_BIT = 7;
  localparam int unsigned BZ_TMR_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // clock dividers for the instruction clock and the special high oscillator
  localparam int unsigned INSTR_DIV   = 2;
  localparam int unsigned SPECIAL_DIV = 2;
  localparam int unsigned DIV_W       = 4;
  localparam logic [DIV_W-1:0] DIV_ZERO = 4'h0;
  localparam logic [DIV_W-1:0] DIV_ONE  = 4'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // control register field layouts
  typedef struct packed {
    logic pwm_pin_enable;
    logic pwm_active_low;
    logic toggle_out_enable;
    logic special_osc_clock_select;
    logic high_osc_clock_select;
    logic one_shot_select;
    logic reload_select;
    logic counter_enable;
  } dtp_ctrl_one_t;

  typedef struct packed {
    logic [1:0] unused;
    logic       ext_clock_select;
    logic       ext_edge_select;
    logic       prescale_disable_n;
    logic [2:0] prescale_rate;
  } dtp_ctrl_two_t;

  // shared pin drive pair
  typedef struct packed {
    logic level;
    logic oe;
  } dtp_pin_t;

endpackage

/* File: design/dtp_edge_sync.sv */
// two-flop synchroniser for the external clock pin with edge selection
// assumes the pin is asynchronous to clk_i and much slower than it
`timescale 1ns/100ps
module dtp_edge_sync
(
  input  wire logic clk_i,          // system clock
  input  wire logic rst_n_i,        // async reset, active low
  input  wire logic pin_i,          // raw external clock pin
  input  wire logic falling_sel_i,  // 1 selects high-to-low edges
  output logic      edge_o          // one-cycle pulse on the selected edge
);
  import dtp_pkg::*;

  logic meta_q;
  logic sync_q;
  logic last_q;

  ////////////////////////////////////////////////////////////////////////////////
  // synchroniser chain, meta_q feeds only sync_q
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // edge pick from the synchronised level
  assign edge_o = falling_sel_i ? (last_q & ~sync_q) : (~last_q & sync_q);  // see (R15)

endmodule

/* File: design/dtp_prescaler.sv */
// power-of-two prescaler, down counter readable by software
// assumes src_tick_i is a one-cycle enable on the system clock
`timescale 1ns/100ps
module dtp_prescaler
(
  input  wire logic       clk_i,       // system clock
  input  wire logic       rst_n_i,     // async reset, active low
  input  wire logic       src_tick_i,  // selected source tick
  input  wire logic       bypass_i,    // 1 disables the prescaler
  input  wire logic [2:0] rate_i,      // division code
  output logic [7:0]      count_o,     // present prescaler count
  output logic            tick_o       // divided tick
);
  import dtp_pkg::*;

  logic [REG_W-1:0] count_q;
  logic [REG_W-1:0] mask;

  ////////////////////////////////////////////////////////////////////////////////
  // counter steps down on each source tick while enabled
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= RST_PRESCALER;  // see (R18)
    else if (src_tick_i && !bypass_i)
      count_q <= count_q - 8'h01;
  end

  // code n gives a tick every 2^(n+1) source ticks
  assign mask    = ~REG_W'(8'hfe << rate_i);                                 // see (R13)
  assign tick_o  = bypass_i ? src_tick_i : (src_tick_i && ((count_q & mask) == RST_ZERO8));
  assign count_o = count_q;

endmodule

/* File: design/dtp_timer.sv */
// 10-bit down timer with prescaler, toggle output, pwm and buzzer, avalon-mm slave
// assumes one 10 mhz clock; the external clock pin is asynchronous
//
// Summary of operation
// (R1) counter read returns present count
// (R2) counter write loads reload with high bits
// (R3) non-stop, no reload: underflow loads 0x3ff
// (R4) non-stop with reload: underflow loads reload
// (R5) one-shot counts to zero then stops
// (R6) high oscillator select overrides clock source
// (R7) special oscillator select has top priority
// (R8) software disables prescaler with high oscillator
// (R9) polarity bit one makes pwm active low
// (R10) pwm enable routes pwm to pin
// (R11) toggle enable toggles output on underflow
// (R12) toggle output wins the shared pin
// (R13) rate code selects divide 2 to 256
// (R14) software changes rate only while disabled
// (R15) edge bit picks falling or rising edge
// (R16) source bit picks pin or instruction clock
// (R17) pwm period from reload, duty ten bits
// (R18) prescaler value readable, resets to ones
// (R19) buzzer selects prescaler tap or counter bit
// (R20) enable bit freezes or runs the counter
// (R21) pwm active while count below duty
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/100ps
module dtp_timer
(
  input  wire logic                       clk_i,                 // 10 mhz system clock
  input  wire logic                       rst_n_i,               // async reset, active low
  input  wire logic [dtp_pkg::ADDR_W-1:0] avs_address_i,         // byte address
  input  wire logic                       avs_read_i,            // read request
  input  wire logic                       avs_write_i,           // write request
  input  wire logic [dtp_pkg::DATA_W-1:0] avs_writedata_i,       // write data
  input  wire logic [3:0]                 avs_byteenable_i,      // byte lanes
  output logic [dtp_pkg::DATA_W-1:0]      avs_readdata_o,        // read data
  output logic                            avs_waitrequest_o,     // wait while high
  input  wire logic                       ext_clock_pin_i,       // external count clock
  input  wire logic                       gpio_out_i,            // port level when gpio
  input  wire logic                       gpio_oe_i,             // port enable when gpio
  output logic                            shared_port_pin_o,     // shared pin level
  output logic                            shared_port_pin_oe_o,  // shared pin enable
  output logic                            underflow_toggle_out_o, // toggle output
  output logic                            buzzer_o               // buzzer output
);
  import dtp_pkg::*;

  dtp_ctrl_one_t         ctrl_one_q;
  dtp_ctrl_two_t         ctrl_two_q;
  logic [REG_W-1:0]      duty_low_q;
  logic [REG_W-1:0]      buzzer_q;
  logic [REG_W-1:0]      high_bits_q;
  logic [REG_W-1:0]      reload_low_q;
  logic [CNT_W-1:0]      count_q;
  logic [CNT_W-1:0]      count_d;
  logic                  toggle_q;
  logic                  underflow;
  logic                  wait_q;
  logic [DATA_W-1:0]     rdata_q;
  logic                  buzz_q;
  dtp_pin_t              pin_q;
  dtp_pin_t              pin_d;
  logic [DIV_W-1:0]      instr_div_q;
  logic [DIV_W-1:0]      special_div_q;
  logic                  instr_tick;
  logic                  special_tick;
  logic                  ext_edge;
  logic                  src_tick;
  logic                  timer_tick;
  logic [REG_W-1:0]      ps_count;
  logic [IDX_W-1:0]      idx;
  logic                  wr_go;
  logic                  wr_lane0;
  logic [CNT_W-1:0]      reload_val;
  logic [CNT_W-1:0]      duty_val;
  logic                  pwm_level;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode: a transfer completes at the edge where waitrequest is low
  assign idx      = avs_address_i[IDX_LO +: IDX_W];
  assign wr_go    = avs_write_i && !wait_q;
  assign wr_lane0 = wr_go && avs_byteenable_i[0];

  // ten-bit reload and duty values built from the high-bits register
  assign reload_val = {high_bits_q[HB_RELOAD_HI:HB_RELOAD_LO], reload_low_q};  // see (R17)
  assign duty_val   = {high_bits_q[HB_DUTY_HI:HB_DUTY_LO], duty_low_q};        // see (R17)

  ////////////////////////////////////////////////////////////////////////////////
  // waitrequest drops one cycle after a request and rises after the transfer
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wait_q <= 1'b1;
    else if (!wait_q)
      wait_q <= 1'b1;
    else if (avs_read_i || avs_write_i)
      wait_q <= 1'b0;
  end

  // read data captured as waitrequest drops, steady while it is low
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q <= RD_ZERO;
    else if (wait_q && avs_read_i)
    begin
      case (idx)
        IDX_TIMER_COUNT:       rdata_q <= {24'h000000, count_q[REG_W-1:0]};  // see (R1)
        IDX_TIMER_CONTROL_ONE: rdata_q <= {24'h000000, ctrl_one_q};
        IDX_TIMER_CONTROL_TWO: rdata_q <= {24'h000000, ctrl_two_q};
        IDX_PRESCALER_VALUE:   rdata_q <= {24'h000000, ps_count};            // see (R18)
        IDX_TIMER_HIGH_BITS:   rdata_q <= {24'h000000, count_q[CNT_W-1:REG_W],
                                           high_bits_q[5:0]};                // see (R1)
        default:               rdata_q <= RD_ZERO;
      endcase
    end
    else if (!wait_q)
      rdata_q <= RD_ZERO;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control register one
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_one_q <= dtp_ctrl_one_t'(RST_CONTROL_ONE);
    else if (wr_lane0 && idx == IDX_TIMER_CONTROL_ONE)
      ctrl_one_q <= dtp_ctrl_one_t'(avs_writedata_i[REG_W-1:0]);
  end

  // control register two, top two bits unused
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ctrl_two_q <= dtp_ctrl_two_t'(RST_CONTROL_TWO);
    else if (wr_lane0 && idx == IDX_TIMER_CONTROL_TWO)
      ctrl_two_q <= dtp_ctrl_two_t'(avs_writedata_i[REG_W-1:0] & RST_CONTROL_TWO);
  end

  // duty low byte, write only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      duty_low_q <= RST_ZERO8;
    else if (wr_lane0 && idx == IDX_PWM_DUTY_LOW)
      duty_low_q <= avs_writedata_i[REG_W-1:0];
  end

  // buzzer control, write only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      buzzer_q <= RST_BUZZER;
    else if (wr_lane0 && idx == IDX_BUZZER_CONTROL)
      buzzer_q <= avs_writedata_i[REG_W-1:0];
  end

  // high bits of reload and duty
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      high_bits_q <= RST_ZERO8;
    else if (wr_lane0 && idx == IDX_TIMER_HIGH_BITS)
      high_bits_q <= avs_writedata_i[REG_W-1:0] & HB_WMASK;
  end

  // reload low byte, stored on every counter write
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reload_low_q <= RST_ZERO8;
    else if (wr_lane0 && idx == IDX_TIMER_COUNT)
      reload_low_q <= avs_writedata_i[REG_W-1:0];  // see (R2)
  end

  ////////////////////////////////////////////////////////////////////////////////
  // instruction clock and special oscillator enables
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      instr_div_q <= DIV_ZERO;
    else if (instr_div_q == DIV_W'(INSTR_DIV - 1))
      instr_div_q <= DIV_ZERO;
    else
      instr_div_q <= instr_div_q + DIV_ONE;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      special_div_q <= DIV_ZERO;
    else if (special_div_q == DIV_W'(SPECIAL_DIV - 1))
      special_div_q <= DIV_ZERO;
    else
      special_div_q <= special_div_q + DIV_ONE;
  end

  assign instr_tick   = (instr_div_q == DIV_W'(INSTR_DIV - 1));
  assign special_tick = (special_div_q == DIV_W'(SPECIAL_DIV - 1));

  // external pin synchronised and edge selected
  dtp_edge_sync u_edge
  (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .pin_i         (ext_clock_pin_i),
    .falling_sel_i (ctrl_two_q.ext_edge_select),
    .edge_o        (ext_edge)
  );

  // source select: special osc, then high osc (every cycle), then pin or instruction
  always_comb
  begin
    if (ctrl_one_q.special_osc_clock_select)
      src_tick = special_tick;                                        // see (R7)
    else if (ctrl_one_q.high_osc_clock_select)
      src_tick = 1'b1;                                                // see (R6)
    else if (ctrl_two_q.ext_clock_select)
      src_tick = ext_edge;                                            // see (R16)
    else
      src_tick = instr_tick;                                          // see (R16)
  end

  // prescaler between source and counter
  dtp_prescaler u_presc
  (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .src_tick_i (src_tick),
    .bypass_i   (ctrl_two_q.prescale_disable_n),
    .rate_i     (ctrl_two_q.prescale_rate),
    .count_o    (ps_count),
    .tick_o     (timer_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // counter next value; a bus write beats a tick in the same cycle
  always_comb
  begin
    count_d   = count_q;
    underflow = 1'b0;
    if (wr_lane0 && idx == IDX_TIMER_COUNT)
      count_d = {high_bits_q[HB_RELOAD_HI:HB_RELOAD_LO],
                 avs_writedata_i[REG_W-1:0]};                         // see (R2)
    else if (timer_tick && ctrl_one_q.counter_enable)                 // see (R20)
    begin
      if (ctrl_one_q.one_shot_select)
      begin
        if (count_q != CNT_ZERO)
          count_d = count_q - CNT_ONE;                                // see (R5)
        underflow = (count_q == CNT_ONE);                             // see (R5)
      end
      else if (count_q == CNT_ZERO)
      begin
        underflow = 1'b1;
        count_d   = ctrl_one_q.reload_select ? reload_val : CNT_FULL; // see (R3) (R4)
      end
      else
        count_d = count_q - CNT_ONE;
    end
  end

  // counter register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= RST_COUNT;
    else
      count_q <= count_d;
  end

  // toggle output flips on each underflow while enabled
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      toggle_q <= 1'b0;
    else if (underflow && ctrl_one_q.toggle_out_enable)
      toggle_q <= ~toggle_q;                                          // see (R11)
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pwm level with polarity and shared pin mux
  assign pwm_level = (count_q < duty_val) ^ ctrl_one_q.pwm_active_low;  // see (R21) (R9)

  always_comb
  begin
    if (ctrl_one_q.toggle_out_enable)
      pin_d = '{level: toggle_q, oe: 1'b1};                           // see (R11) (R12)
    else if (ctrl_one_q.pwm_pin_enable)
      pin_d = '{level: pwm_level, oe: 1'b1};                          // see (R10)
    else
      pin_d = '{level: gpio_out_i, oe: gpio_oe_i};                    // see (R10)
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_q <= '{level: 1'b0, oe: 1'b0};
    else
      pin_q <= pin_d;
  end

  // buzzer: prescaler tap for codes 0-7, counter bit for 8-15
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      buzz_q <= 1'b0;
    else if (!buzzer_q[BZ_EN_BIT])
      buzz_q <= 1'b0;
    else if (buzzer_q[BZ_TMR_BIT])
      buzz_q <= count_q[buzzer_q[2:0]];                               // see (R19)
    else
      buzz_q <= ps_count[buzzer_q[2:0]];                              // see (R19)
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata_o         = rdata_q;
  assign avs_waitrequest_o      = wait_q;
  assign shared_port_pin_o      = pin_q.level;
  assign shared_port_pin_oe_o   = pin_q.oe;
  assign underflow_toggle_out_o = toggle_q;
  assign buzzer_o               = buzz_q;

endmodule

/* File: test/dtp_timer_chk.sv */
// timer checker: bus handshake, shared pin routing, buzzer gating
// assumes it is bound to dtp_timer and sees only that module's ports
`timescale 1ns/100ps
module dtp_timer_chk
(
  input wire logic        clk_i,                  // clock
  input wire logic        rst_n_i,                // reset
  input wire logic [4:0]  avs_address_i,          // address
  input wire logic        avs_read_i,             // read
  input wire logic        avs_write_i,            // write
  input wire logic [31:0] avs_writedata_i,        // write data
  input wire logic [3:0]  avs_byteenable_i,       // lanes
  input wire logic [31:0] avs_readdata_o,         // read data
  input wire logic        avs_waitrequest_o,      // wait
  input wire logic        ext_clock_pin_i,        // ext clock
  input wire logic        gpio_out_i,             // gpio level
  input wire logic        gpio_oe_i,              // gpio enable
  input wire logic        shared_port_pin_o,      // pin level
  input wire logic        shared_port_pin_oe_o,   // pin enable
  input wire logic        underflow_toggle_out_o, // toggle
  input wire logic        buzzer_o                // buzzer
);
  import dtp_pkg::*;

  logic tog_en_q;
  logic pwm_en_q;
  logic bz_en_q;
  logic wr_done;

  ////////////////////////////////////////////////////////////////////////////
  // a write lands where waitrequest is seen low
  assign wr_done = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

  // shadow of the pin enables, to judge routing at the ports
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tog_en_q <= 1'b0;
      pwm_en_q <= 1'b0;
    end
    else if (wr_done && avs_address_i[4:2] == IDX_TIMER_CONTROL_ONE)
    begin
      tog_en_q <= avs_writedata_i[5];
      pwm_en_q <= avs_writedata_i[7];
    end
  end

  // shadow of the buzzer enable
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bz_en_q <= 1'b0;
    else if (wr_done && avs_address_i[4:2] == IDX_BUZZER_CONTROL)
      bz_en_q <= avs_writedata_i[BZ_EN_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wait_pulse_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");
  wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("request not answered");
  wait_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_waitrequest_o)
    && ($past(avs_read_i) || $past(avs_write_i))) else $error("answer without request");
  rd_idle_zero_a: assert property (avs_waitrequest_o |-> avs_readdata_o == RD_ZERO)
    else $error("read data not zero when idle");
  reset_state_a: assert property ($rose(rst_n_i) |-> avs_waitrequest_o
    && !shared_port_pin_oe_o && !underflow_toggle_out_o && !buzzer_o)
    else $error("outputs not at reset state");
  pin_gpio_a: assert property ($past(rst_n_i) && !$past(tog_en_q)
    && !$past(pwm_en_q) |-> shared_port_pin_o == $past(gpio_out_i)
    && shared_port_pin_oe_o == $past(gpio_oe_i)) else $error("pin not general purpose");
  pin_toggle_a: assert property ($past(rst_n_i) && $past(tog_en_q)
    |-> shared_port_pin_oe_o && shared_port_pin_o == $past(underflow_toggle_out_o))
    else $error("pin not carrying toggle");
  pin_pwm_oe_a: assert property ($past(rst_n_i) && $past(pwm_en_q)
    |-> shared_port_pin_oe_o) else $error("pwm pin not driven");
  toggle_hold_a: assert property ($past(rst_n_i) && !$past(tog_en_q)
    |-> $stable(underflow_toggle_out_o)) else $error("toggle moved while disabled");
  buzz_off_a: assert property ($past(rst_n_i) && !$past(bz_en_q) |-> !buzzer_o)
    else $error("buzzer active while disabled");

  cover property (avs_read_i && !avs_waitrequest_o);
  cover property (tog_en_q && pwm_en_q && $changed(underflow_toggle_out_o));
  cover property ($rose(buzzer_o));
endmodule

/* File: test/dtp_timer_tb_top.sv */
// timer bench: register table loop, then clock, pin, pwm and buzzer cases
// assumes the package and the checker are compiled first
`timescale 1ns/100ps
module dtp_timer_tb_top;
  import dtp_pkg::*;

  typedef struct packed {
    logic [4:0] addr;
    logic       wr;
    logic [7:0] data;
    logic [7:0] exp;
  } dtp_row_t;

  localparam int LIMIT = 40000;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  avs_address_i = 5'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        ext_clock_pin_i = 1'b0;
  logic        gpio_out_i = 1'b0;
  logic        gpio_oe_i = 1'b0;
  logic        shared_port_pin_o;
  logic        shared_port_pin_oe_o;
  logic        underflow_toggle_out_o;
  logic        buzzer_o;
  int          err_total = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          n_tog;
  int          n_hi;
  int          n_bz;
  logic [31:0] q;
  logic        t;
  dtp_row_t    rows [10] = '{'{5'h08, 1'b1, 8'hff, 8'h3f}, '{5'h0c, 1'b1, 8'h55, 8'h00},
    '{5'h10, 1'b1, 8'h00, 8'hff}, '{5'h14, 1'b1, 8'h0f, 8'h00}, '{5'h1c, 1'b1, 8'haa, 8'h00},
    '{5'h18, 1'b1, 8'hff, 8'h33}, '{5'h00, 1'b1, 8'ha5, 8'ha5}, '{5'h18, 1'b0, 8'h00, 8'hf3},
    '{5'h04, 1'b1, 8'h5a, 8'h5a}, '{5'h04, 1'b1, 8'h00, 8'h00}};

  dtp_timer dtp_timer_inst (.*);

  // 100 ns clock
  always #50 clk_i = ~clk_i;

  // gpio stimulus and the run ceiling
  always @(posedge clk_i)
  begin
    cyc++;
    gpio_out_i <= cyc[1];
    gpio_oe_i <= cyc[2];
    if (cyc == LIMIT)
    begin
      err_total++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest low
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, d};
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    check(q, {24'h0, e});
  endtask

  task automatic rng(input int n, input int lo, input int hi);
    check({31'h0, n >= lo && n <= hi}, 32'h1);
  endtask

  // counts toggle flips, pin-high and buzzer-high cycles
  task automatic measure(input int c);
    n_tog = 0;
    n_hi = 0;
    n_bz = 0;
    repeat (c)
    begin
      t = underflow_toggle_out_o;
      @(posedge clk_i);
      n_tog += (underflow_toggle_out_o !== t);
      n_hi += (shared_port_pin_o === 1'b1);
      n_bz += (buzzer_o === 1'b1);
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // register table: write then read back
    foreach (rows[i])
    begin
      if (rows[i].wr)
        bus(rows[i].addr, 1'b1, rows[i].data);
      rd_chk(rows[i].addr, rows[i].exp);
    end
    // frozen counter, masked write lane ignored
    bus(5'h08, 1'b1, 8'h08);
    repeat (20) @(posedge clk_i);
    rd_chk(5'h00, 8'ha5);
    avs_byteenable_i <= 4'h0;
    bus(5'h04, 1'b1, 8'hff);
    avs_byteenable_i <= 4'hf;
    rd_chk(5'h04, 8'h00);
    // count modes from 3, instruction clock, prescaler off
    bus(5'h18, 1'b1, 8'h00);
    bus(5'h04, 1'b1, 8'h07);
    bus(5'h00, 1'b1, 8'h03);
    repeat (40) @(posedge clk_i);
    rd_chk(5'h00, 8'h00);
    bus(5'h04, 1'b1, 8'h01);
    bus(5'h00, 1'b1, 8'h03);
    repeat (20) @(posedge clk_i);
    rd_chk(5'h18, 8'hc0);
    bus(5'h04, 1'b1, 8'h03);
    bus(5'h00, 1'b1, 8'h03);
    repeat (20) @(posedge clk_i);
    rd_chk(5'h18, 8'h00);
    // toggle rate per source: instruction, high osc, special over high osc
    for (int s = 0; s < 3; s++)
    begin
      bus(5'h04, 1'b1, s == 0 ? 8'ha3 : (s == 1 ? 8'hab : 8'hbb));
      measure(80);
      rng(n_tog, s == 1 ? 18 : 8, s == 1 ? 22 : 12);
    end
    // external edges; count 0 with reload 0 toggles on each counted edge
    bus(5'h04, 1'b1, 8'h23);
    bus(5'h00, 1'b1, 8'h00);
    for (int e = 0; e < 2; e++)
    begin
      bus(5'h08, 1'b1, {2'h0, 1'b1, e[0], 4'h8});
      @(posedge clk_i);
      repeat (2)
      begin
        t = underflow_toggle_out_o;
        ext_clock_pin_i <= ~ext_clock_pin_i;
        repeat (8) @(posedge clk_i);
        check({31'h0, underflow_toggle_out_o ^ t}, {31'h0, ext_clock_pin_i ^ e[0]});
      end
    end
    // prescaler rates, code changed only while disabled
    for (int r = 0; r < 8; r++)
    begin
      bus(5'h08, 1'b1, {5'h01, r[2:0]});
      bus(5'h08, 1'b1, {5'h00, r[2:0]});
      measure(1024);
      rng(n_tog, (1024 >> (r + 2)) - 1, (1024 >> (r + 2)) + 1);
      bus(5'h08, 1'b1, {5'h01, r[2:0]});
    end
    // pwm frame 0x10f, duty 0x104, both polarities
    bus(5'h08, 1'b1, 8'h08);
    bus(5'h18, 1'b1, 8'h11);
    bus(5'h0c, 1'b1, 8'h04);
    bus(5'h00, 1'b1, 8'h0f);
    for (int p = 0; p < 2; p++)
    begin
      bus(5'h04, 1'b1, {1'b1, p[0], 6'h03});
      measure(544);
      rng(n_hi, p ? 20 : 516, p ? 28 : 524);
    end
    // every buzzer tap shows activity, then the buzzer goes quiet
    bus(5'h18, 1'b1, 8'h00);
    bus(5'h00, 1'b1, 8'hff);
    bus(5'h04, 1'b1, 8'h03);
    bus(5'h08, 1'b1, 8'h00);
    for (int b = 0; b < 16; b++)
    begin
      bus(5'h14, 1'b1, {4'h8, b[3:0]});
      measure(600);
      rng(n_bz, 1, 600);
    end
    bus(5'h14, 1'b1, 8'h0f);
    @(posedge clk_i);
    measure(40);
    rng(n_bz, 0, 0);
    // second reset in mid-run restores the reset values
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(5'h04, RST_CONTROL_ONE);
    rd_chk(5'h08, RST_CONTROL_TWO);
    rd_chk(5'h10, RST_PRESCALER);
    rd_chk(5'h18, RST_ZERO8);
    rd_chk(5'h00, RST_ZERO8);
    results();
  end
endmodule

bind dtp_timer dtp_timer_chk dtp_timer_chk_inst (.*);
